// file: hdl/pfc_flow_top.sv
`timescale 1ns/1ps
`include "pfc_cfg.svh"
// Notes on behaviour
// - Each transmitted PAUSE frame carries the pause time value held in bits 31:16 of the flow register.
// - In full duplex flow busy stays one while a PAUSE frame is sent and clears when it is done.
// - Flow busy is set by the automatic flow-control start, never by a flow register write.
// - With the transmitter disabled no PAUSE frame is sent and no back pressure is driven.
// - With pass control frames and flow enable set, a valid pause frame sets its packet filter bit.
// - With pass control frames clear and promiscuous off, the packet filter bit of received frames reads zero.
// - The data of every received frame is forwarded.
// - Promiscuous reception overrides pass control frames when the packet filter bit is formed.
// - With flow enable set in full duplex, a valid PAUSE stalls the transmitter for time times slot time.
// - With flow enable clear, no frame is decoded as a PAUSE and no pause is obeyed.
// - In half duplex, flow enable turns on back pressure instead of pause handling.
// - PAUSE transmission is started through the separate auto flow config register or the request pin.
module pfc_flow_top
    import pfc_pkg::*;
#(
    parameter int SLOT_CYCLES_100 = `PFC_SLOT_BITS * `PFC_BIT_NS_100 / `PFC_CLK_NS,
    parameter int SLOT_CYCLES_10  = `PFC_SLOT_BITS * `PFC_BIT_NS_10 / `PFC_CLK_NS
)
(
    input  logic               I_REF_CLK,
    input  logic               I_SYS_RST,
    input  logic [`PFC_AW-1:0] I_AXI_AWADDR,
    input  logic               I_AXI_AWVALID,
    output logic               O_AXI_AWREADY,
    input  logic [31:0]        I_AXI_WDATA,
    input  logic [3:0]         I_AXI_WSTRB,
    input  logic               I_AXI_WVALID,
    output logic               O_AXI_WREADY,
    output logic [1:0]         O_AXI_BRESP,
    output logic               O_AXI_BVALID,
    input  logic               I_AXI_BREADY,
    input  logic [`PFC_AW-1:0] I_AXI_ARADDR,
    input  logic               I_AXI_ARVALID,
    output logic               O_AXI_ARREADY,
    output logic [31:0]        O_AXI_RDATA,
    output logic [1:0]         O_AXI_RRESP,
    output logic               O_AXI_RVALID,
    input  logic               I_AXI_RREADY,
    input  logic               I_AUTO_PAUSE_REQ,
    output logic               O_PAUSE_TX_REQ,
    output logic [15:0]        O_PAUSE_TX_TIME,
    input  logic               I_PAUSE_TX_DONE,
    output logic               O_TX_STALL,
    input  logic               I_RX_CONGESTED,
    output logic               O_BACK_PRESSURE,
    input  logic               I_RX_VALID,
    input  logic [7:0]         I_RX_DATA,
    input  logic               I_RX_SOF,
    input  logic               I_RX_EOF,
    input  logic               I_RX_ERR,
    output logic               O_RX_VALID,
    output logic [7:0]         O_RX_DATA,
    output logic               O_RX_SOF,
    output logic               O_RX_EOF,
    output logic               O_RX_STATUS_VALID,
    output logic               O_RX_STATUS_FILTER,
    output logic               O_RX_STATUS_ERR
);
    localparam int CNT_MAX = (1 << `PFC_CNT_W) - 1;

    generate
        if (SLOT_CYCLES_100 < 1 || SLOT_CYCLES_100 > CNT_MAX || SLOT_CYCLES_10 < 1 || SLOT_CYCLES_10 > CNT_MAX)
        begin : g_bad_slot
            $error("Slot cycle parameters do not fit the slot counter.");
        end
    endgenerate

    pfc_top_s              st;
    pfc_top_s              next_st;
    logic                  det_done;
    logic                  det_pause;
    logic                  det_err;
    logic [15:0]           det_time;
    logic                  pause_load;
    logic                  stall;
    logic [15:0]           stall_left;
    logic [`PFC_CNT_W-1:0] slot_cycles;
    logic                  wr_fire;
    logic                  start_pause;

    // One quantum is a slot of 512 bit times.
    assign slot_cycles = st.speed10 ? `PFC_CNT_W'(SLOT_CYCLES_10) : `PFC_CNT_W'(SLOT_CYCLES_100);

    pfc_pause_detect u_detect (
        .i_clk        (I_REF_CLK),
        .i_rst        (I_SYS_RST),
        .i_enable     (st.flow_en),
        .i_valid      (I_RX_VALID),
        .i_data       (I_RX_DATA),
        .i_sof        (I_RX_SOF),
        .i_eof        (I_RX_EOF),
        .i_err        (I_RX_ERR),
        .o_done       (det_done),
        .o_is_pause   (det_pause),
        .o_err        (det_err),
        .o_pause_time (det_time)
    );

    // A decoded pause is obeyed only with flow enable set in full duplex.
    assign pause_load = det_done & det_pause & st.flow_en & st.full_duplex;

    pfc_slot_timer u_timer (
        .i_clk         (I_REF_CLK),
        .i_rst         (I_SYS_RST),
        .i_load        (pause_load),
        .i_quanta      (det_time),
        .i_slot_cycles (slot_cycles),
        .o_active      (stall),
        .o_remaining   (stall_left)
    );

    assign wr_fire = st.aw_got & st.w_got & ~st.bvalid;

    // A pause frame starts from auto flow config or the request pin.
    always_comb
    begin
        logic req;
        req = I_AUTO_PAUSE_REQ;
        if (wr_fire && st.awaddr == `PFC_ADDR_AUTO && st.wstrb[0] && st.wdata[`PFC_AUTO_SEND])
            req = 1'b1;
        start_pause = req & st.full_duplex & st.tx_en & ~st.busy;
    end

    function automatic logic [31:0] read_word(input pfc_top_s s, input logic [`PFC_AW-1:0] a,
                                              input logic stl, input logic [15:0] left);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == `PFC_ADDR_FLOW)
        begin
            v[`PFC_FLOW_PT_HI:`PFC_FLOW_PT_LO] = s.pause_time;
            v[`PFC_FLOW_PASS] = s.pass_ctrl;
            v[`PFC_FLOW_EN] = s.flow_en;
            v[`PFC_FLOW_BUSY] = s.busy;
        end
        else if (a == `PFC_ADDR_CTRL)
        begin
            v[`PFC_CTRL_FDX] = s.full_duplex;
            v[`PFC_CTRL_TXEN] = s.tx_en;
            v[`PFC_CTRL_PROM] = s.promisc;
            v[`PFC_CTRL_SPD10] = s.speed10;
        end
        else if (a == `PFC_ADDR_STAT)
        begin
            v[31:16] = left;
            v[`PFC_STAT_STALL] = stl;
            v[`PFC_STAT_BP] = s.bp;
        end
        read_word = v;
    endfunction : read_word

    function automatic logic addr_ok(input logic [`PFC_AW-1:0] a);
        addr_ok = (a == `PFC_ADDR_FLOW) || (a == `PFC_ADDR_AUTO) || (a == `PFC_ADDR_CTRL) || (a == `PFC_ADDR_STAT);
    endfunction : addr_ok

    always_comb
    begin
        next_st = st;
        if (I_AXI_AWVALID && O_AXI_AWREADY)
        begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = I_AXI_AWADDR;
        end
        if (I_AXI_WVALID && O_AXI_WREADY)
        begin
            next_st.w_got = 1'b1;
            next_st.wdata = I_AXI_WDATA;
            next_st.wstrb = I_AXI_WSTRB;
        end
        if (wr_fire)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = addr_ok(st.awaddr) ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
            if (st.awaddr == `PFC_ADDR_FLOW)
            begin
                if (st.wstrb[3])
                    next_st.pause_time[15:8] = st.wdata[31:24];
                if (st.wstrb[2])
                    next_st.pause_time[7:0] = st.wdata[23:16];
                if (st.wstrb[0])
                begin
                    next_st.pass_ctrl = st.wdata[`PFC_FLOW_PASS];
                    next_st.flow_en = st.wdata[`PFC_FLOW_EN];
                end
            end
            if (st.awaddr == `PFC_ADDR_CTRL && st.wstrb[0])
            begin
                next_st.full_duplex = st.wdata[`PFC_CTRL_FDX];
                next_st.tx_en = st.wdata[`PFC_CTRL_TXEN];
                next_st.promisc = st.wdata[`PFC_CTRL_PROM];
                next_st.speed10 = st.wdata[`PFC_CTRL_SPD10];
            end
        end
        else if (st.bvalid && I_AXI_BREADY)
            next_st.bvalid = 1'b0;
        if (st.rvalid && I_AXI_RREADY)
            next_st.rvalid = 1'b0;
        if (I_AXI_ARVALID && O_AXI_ARREADY)
        begin
            next_st.rvalid = 1'b1;
            next_st.rdata = read_word(st, I_AXI_ARADDR, stall, stall_left);
            next_st.rresp = addr_ok(I_AXI_ARADDR) ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
        end
        // Done clears busy; a start in that cycle is refused.
        if (st.busy && I_PAUSE_TX_DONE)
            next_st.busy = 1'b0;
        if (start_pause)
        begin
            next_st.busy = 1'b1;
            next_st.tx_time = st.pause_time;
        end
        next_st.bp = ~st.full_duplex & st.flow_en & st.tx_en & I_RX_CONGESTED;
        next_st.rx_valid = I_RX_VALID;
        next_st.rx_data = I_RX_DATA;
        next_st.rx_sof = I_RX_SOF & I_RX_VALID;
        next_st.rx_eof = I_RX_EOF & I_RX_VALID;
    end

    // Status comes with the forwarded last byte.
    always_comb
    begin
        O_RX_STATUS_VALID = det_done;
        O_RX_STATUS_ERR = det_err;
        if (st.promisc)
            O_RX_STATUS_FILTER = det_done;
        else
            O_RX_STATUS_FILTER = det_done & st.pass_ctrl & det_pause;
    end

    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SYS_RST)
        begin
            st <= '0;
            st.pause_time <= `PFC_RST_PT;
            st.bresp <= `PFC_RESP_OKAY;
            st.rresp <= `PFC_RESP_OKAY;
        end
        else
            st <= next_st;
    end

    assign O_AXI_AWREADY   = ~st.aw_got & ~st.bvalid;
    assign O_AXI_WREADY    = ~st.w_got & ~st.bvalid;
    assign O_AXI_BVALID    = st.bvalid;
    assign O_AXI_BRESP     = st.bresp;
    assign O_AXI_ARREADY   = ~st.rvalid;
    assign O_AXI_RVALID    = st.rvalid;
    assign O_AXI_RDATA     = st.rdata;
    assign O_AXI_RRESP     = st.rresp;
    assign O_PAUSE_TX_REQ  = st.busy;
    assign O_PAUSE_TX_TIME = st.tx_time;
    assign O_TX_STALL      = stall;
    assign O_BACK_PRESSURE = st.bp;
    assign O_RX_VALID      = st.rx_valid;
    assign O_RX_DATA       = st.rx_data;
    assign O_RX_SOF        = st.rx_sof;
    assign O_RX_EOF        = st.rx_eof;
endmodule : pfc_flow_top

// file: hdl/pfc_cfg.svh
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH
`define PFC_AW             8
`define PFC_CNT_W          16
`define PFC_IDX_FLOW       8'h08
`define PFC_IDX_AUTO       8'h10
`define PFC_IDX_CTRL       8'h11
`define PFC_IDX_STAT       8'h12
`define PFC_ADDR_FLOW      (`PFC_IDX_FLOW << 2)
`define PFC_ADDR_AUTO      (`PFC_IDX_AUTO << 2)
`define PFC_ADDR_CTRL      (`PFC_IDX_CTRL << 2)
`define PFC_ADDR_STAT      (`PFC_IDX_STAT << 2)
`define PFC_FLOW_PT_HI     31
`define PFC_FLOW_PT_LO     16
`define PFC_FLOW_PASS      2
`define PFC_FLOW_EN        1
`define PFC_FLOW_BUSY      0
`define PFC_AUTO_SEND      0
`define PFC_CTRL_FDX       0
`define PFC_CTRL_TXEN      1
`define PFC_CTRL_PROM      2
`define PFC_CTRL_SPD10     3
`define PFC_STAT_STALL     0
`define PFC_STAT_BP        1
`define PFC_RST_PT         16'h0000
`define PFC_RESP_OKAY      2'h0
`define PFC_RESP_SLVERR    2'h2
`define PFC_CLK_NS         10
`define PFC_SLOT_BITS      512
`define PFC_BIT_NS_100     10
`define PFC_BIT_NS_10      100
`define PFC_ETYPE_HI       8'h88
`define PFC_ETYPE_LO       8'h08
`define PFC_OPC_HI         8'h00
`define PFC_OPC_LO         8'h01
`define PFC_DA_B0          8'h01
`define PFC_DA_B1          8'h80
`define PFC_DA_B2          8'hC2
`define PFC_DA_B5          8'h01
`define PFC_HDR_LEN        5'h12
`endif

// file: hdl/pfc_pkg.sv
`include "pfc_cfg.svh"
package pfc_pkg;
    typedef struct packed {
        logic               aw_got;
        logic [`PFC_AW-1:0] awaddr;
        logic               w_got;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
        logic [15:0]        pause_time;
        logic               pass_ctrl;
        logic               flow_en;
        logic               busy;
        logic               full_duplex;
        logic               tx_en;
        logic               promisc;
        logic               speed10;
        logic [15:0]        tx_time;
        logic               rx_valid;
        logic [7:0]         rx_data;
        logic               rx_sof;
        logic               rx_eof;
        logic               st_filter;
        logic               st_err;
        logic               bp;
    } pfc_top_s;
    typedef struct packed {
        logic [4:0]  idx;
        logic        match;
        logic [15:0] ptime;
        logic        done;
        logic        is_pause;
        logic        err;
        logic [15:0] out_time;
    } pfc_det_s;
    typedef struct packed {
        logic [15:0]           quanta;
        logic [`PFC_CNT_W-1:0] cycles;
    } pfc_tmr_s;
endpackage : pfc_pkg

// file: hdl/pfc_pause_detect.sv
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module pfc_pause_detect
    import pfc_pkg::*;
(
    input  logic        i_clk,
    input  logic        i_rst,
    input  logic        i_enable,
    input  logic        i_valid,
    input  logic [7:0]  i_data,
    input  logic        i_sof,
    input  logic        i_eof,
    input  logic        i_err,
    output logic        o_done,
    output logic        o_is_pause,
    output logic        o_err,
    output logic [15:0] o_pause_time
);
    pfc_det_s st;
    pfc_det_s next_st;

    function automatic logic byte_ok(input logic [4:0] b, input logic [7:0] d);
        case (b)
            5'h00:   byte_ok = (d == `PFC_DA_B0);
            5'h01:   byte_ok = (d == `PFC_DA_B1);
            5'h02:   byte_ok = (d == `PFC_DA_B2);
            5'h03:   byte_ok = (d == 8'h00);
            5'h04:   byte_ok = (d == 8'h00);
            5'h05:   byte_ok = (d == `PFC_DA_B5);
            5'h0C:   byte_ok = (d == `PFC_ETYPE_HI);
            5'h0D:   byte_ok = (d == `PFC_ETYPE_LO);
            5'h0E:   byte_ok = (d == `PFC_OPC_HI);
            5'h0F:   byte_ok = (d == `PFC_OPC_LO);
            default: byte_ok = 1'b1;
        endcase
    endfunction : byte_ok

    always_comb
    begin
        logic [4:0] b;
        logic       m;
        b = i_sof ? 5'h00 : st.idx;
        m = i_sof ? 1'b1 : st.match;
        next_st = st;
        next_st.done = 1'b0;
        if (i_valid)
        begin
            next_st.match = m & byte_ok(b, i_data);
            if (b == 5'h10)
                next_st.ptime[15:8] = i_data;
            if (b == 5'h11)
                next_st.ptime[7:0] = i_data;
            if (b != `PFC_HDR_LEN)
                next_st.idx = b + 5'h01;
            else
                next_st.idx = b;
            if (i_eof)
            begin
                next_st.done = 1'b1;
                next_st.err = i_err;
                next_st.is_pause = i_enable & next_st.match & ~i_err & (next_st.idx == `PFC_HDR_LEN);
                next_st.out_time = {(b == 5'h10) ? i_data : next_st.ptime[15:8], next_st.ptime[7:0]};
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign o_done       = st.done;
    assign o_is_pause   = st.is_pause;
    assign o_err        = st.err;
    assign o_pause_time = st.out_time;
endmodule : pfc_pause_detect

// file: hdl/pfc_slot_timer.sv
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module pfc_slot_timer
    import pfc_pkg::*;
(
    input  logic                  i_clk,
    input  logic                  i_rst,
    input  logic                  i_load,
    input  logic [15:0]           i_quanta,
    input  logic [`PFC_CNT_W-1:0] i_slot_cycles,
    output logic                  o_active,
    output logic [15:0]           o_remaining
);
    pfc_tmr_s st;
    pfc_tmr_s next_st;

    always_comb
    begin
        next_st = st;
        if (i_load)
        begin
            next_st.quanta = i_quanta;
            next_st.cycles = i_slot_cycles - `PFC_CNT_W'(1);
        end
        else if (st.quanta != 16'h0000)
        begin
            if (st.cycles == '0)
            begin
                next_st.quanta = st.quanta - 16'h0001;
                next_st.cycles = i_slot_cycles - `PFC_CNT_W'(1);
            end
            else
                next_st.cycles = st.cycles - `PFC_CNT_W'(1);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            st <= '0;
        else
            st <= next_st;
    end

    assign o_active    = (st.quanta != 16'h0000);
    assign o_remaining = st.quanta;
endmodule : pfc_slot_timer

// file: tb/pfc_flow_asserts.sv
`timescale 1ns/1ps
module pfc_flow_asserts
    import pfc_pkg::*;
#(
    parameter int SLOT_CYCLES_100 = 512
)
(
    input logic        I_REF_CLK,
    input logic        I_SYS_RST,
    input logic [1:0]  O_AXI_BRESP,
    input logic        O_AXI_BVALID,
    input logic        I_AXI_BREADY,
    input logic [31:0] O_AXI_RDATA,
    input logic        O_AXI_RVALID,
    input logic        I_AXI_RREADY,
    input logic        I_AUTO_PAUSE_REQ,
    input logic        O_PAUSE_TX_REQ,
    input logic [15:0] O_PAUSE_TX_TIME,
    input logic        I_PAUSE_TX_DONE,
    input logic        O_TX_STALL,
    input logic        I_RX_CONGESTED,
    input logic        O_BACK_PRESSURE,
    input logic        I_RX_VALID,
    input logic [7:0]  I_RX_DATA,
    input logic        O_RX_VALID,
    input logic [7:0]  O_RX_DATA,
    input logic        O_RX_EOF,
    input logic        O_RX_STATUS_VALID
);
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    logic [19:0] stall_len;
    always_ff @(posedge I_REF_CLK)
    begin
        stall_len <= (I_SYS_RST || !O_TX_STALL) ? 20'h00000 : stall_len + 20'h00001;
    end
    busy_hold_a: assert property (O_PAUSE_TX_REQ && !I_PAUSE_TX_DONE |=> O_PAUSE_TX_REQ)
        else $error("busy dropped");
    busy_clear_a: assert property (O_PAUSE_TX_REQ && I_PAUSE_TX_DONE |=> !O_PAUSE_TX_REQ)
        else $error("busy not cleared");
    busy_cause_a: assert property ($rose(O_PAUSE_TX_REQ) |-> $past(I_AUTO_PAUSE_REQ) || $rose(O_AXI_BVALID))
        else $error("busy without start");
    time_hold_a: assert property (O_PAUSE_TX_REQ && $past(O_PAUSE_TX_REQ) |-> $stable(O_PAUSE_TX_TIME))
        else $error("pause time changed");
    fwd_valid_a: assert property (O_RX_VALID == $past(I_RX_VALID))
        else $error("byte not forwarded");
    fwd_data_a: assert property (O_RX_VALID |-> O_RX_DATA == $past(I_RX_DATA))
        else $error("receive data altered");
    status_eof_a: assert property (O_RX_STATUS_VALID == O_RX_EOF)
        else $error("status not with last byte");
    stall_cause_a: assert property ($rose(O_TX_STALL) |-> $past(O_RX_STATUS_VALID))
        else $error("stall without pause");
    stall_len_a: assert property ($fell(O_TX_STALL) |-> stall_len >= SLOT_CYCLES_100)
        else $error("stall too short");
    bp_cause_a: assert property (O_BACK_PRESSURE |-> $past(I_RX_CONGESTED))
        else $error("bp without congestion");
    bp_drop_a: assert property (!I_RX_CONGESTED |=> !O_BACK_PRESSURE)
        else $error("bp held");
    bresp_hold_a: assert property (O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID && $stable(O_AXI_BRESP))
        else $error("bresp not held");
    rdata_hold_a: assert property (O_AXI_RVALID && !I_AXI_RREADY |=> O_AXI_RVALID && $stable(O_AXI_RDATA))
        else $error("rdata not held");
endmodule : pfc_flow_asserts
bind pfc_flow_top pfc_flow_asserts #(.SLOT_CYCLES_100(SLOT_CYCLES_100)) i_chk (.*);

// file: tb/pfc_link_peer.sv
`timescale 1ns/1ps
module pfc_link_peer
(
    input  logic       i_clk,
    input  logic       i_req,
    output logic       o_done,
    output logic       o_valid,
    output logic [7:0] o_data,
    output logic       o_sof,
    output logic       o_eof,
    output logic       o_err
);
    logic [7:0] frame [18];
    int         wait_cyc = 0;
    int         cnt      = 0;
    initial
    begin
        o_done  = 1'h0;
        o_valid = 1'h0;
        o_data  = 8'h00;
        o_sof   = 1'h0;
        o_eof   = 1'h0;
        o_err   = 1'h0;
    end
    // Done pulse after wait_cyc cycles.
    always @(posedge i_clk)
    begin
        cnt    <= (i_req && !o_done) ? cnt + 1 : 0;
        o_done <= i_req && !o_done && cnt >= wait_cyc;
    end
    // Idle data shows the inverse of the last byte.
    task automatic send(input logic [15:0] q, input logic bad);
        frame = '{8'h01, 8'h80, 8'hC2, 8'h00, 8'h00, 8'h01, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
                  8'h88, 8'h08, 8'h00, 8'h01, q[15:8], q[7:0]};
        for (int i = 0; i < 18; i++)
        begin
            @(posedge i_clk);
            o_valid <= 1'h1;
            o_data  <= frame[i];
            o_sof   <= (i == 0);
            o_eof   <= (i == 17);
            o_err   <= bad && (i == 17);
        end
        @(posedge i_clk);
        o_valid <= 1'h0;
        o_data  <= ~frame[17];
        o_sof   <= 1'h0;
        o_eof   <= 1'h0;
        o_err   <= 1'h0;
    endtask : send
endmodule : pfc_link_peer

// file: tb/test_mac_pause_flow_control.sv
`timescale 1ns/1ps
`include "pfc_cfg.svh"
module test_mac_pause_flow_control
    import pfc_pkg::*;
;
    localparam int         S100   = 4;
    localparam int         S10    = 8;
    localparam logic [7:0] A_FLOW = `PFC_ADDR_FLOW;
    localparam logic [7:0] A_AUTO = `PFC_ADDR_AUTO;
    localparam logic [7:0] A_CTRL = `PFC_ADDR_CTRL;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rxd, od;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, auto_req = 1'h0, cong = 1'h0;
    logic        tx_req, tx_done, stall, bp, rxv, rxs, rxe, rxerr, ov, os, oe, sv, sf, se, got_f, got_e;
    logic [15:0] tx_time;
    int          bad_count = 0;
    int          total_checks = 0;
    int          stall_n = 0;
    int          byte_n = 0;
    always #5 clk = ~clk;
    pfc_flow_top #(.SLOT_CYCLES_100(S100), .SLOT_CYCLES_10(S10)) i_dut (
        .I_REF_CLK(clk), .I_SYS_RST(rst), .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid),
        .O_AXI_AWREADY(awready), .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid),
        .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid), .I_AXI_BREADY(bready),
        .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid), .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata),
        .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready), .I_AUTO_PAUSE_REQ(auto_req),
        .O_PAUSE_TX_REQ(tx_req), .O_PAUSE_TX_TIME(tx_time), .I_PAUSE_TX_DONE(tx_done), .O_TX_STALL(stall),
        .I_RX_CONGESTED(cong), .O_BACK_PRESSURE(bp), .I_RX_VALID(rxv), .I_RX_DATA(rxd), .I_RX_SOF(rxs),
        .I_RX_EOF(rxe), .I_RX_ERR(rxerr), .O_RX_VALID(ov), .O_RX_DATA(od), .O_RX_SOF(os), .O_RX_EOF(oe),
        .O_RX_STATUS_VALID(sv), .O_RX_STATUS_FILTER(sf), .O_RX_STATUS_ERR(se));
    pfc_link_peer i_peer (.i_clk(clk), .i_req(tx_req), .o_done(tx_done), .o_valid(rxv), .o_data(rxd),
        .o_sof(rxs), .o_eof(rxe), .o_err(rxerr));
    always @(posedge clk)
    begin
        stall_n <= stall_n + int'(stall);
        byte_n  <= byte_n + int'(ov) + 100 * int'(os);
        if (sv === 1'h1)
        begin
            got_f <= sf;
            got_e <= se;
        end
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_ok = 1'h0, w_ok = 1'h0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clk);
            aw_ok = aw_ok || awready === 1'h1;
            w_ok  = w_ok || wready === 1'h1;
            awvalid <= !aw_ok;
            wvalid  <= !w_ok;
        end
        do @(posedge clk); while (bvalid !== 1'h1);
        r = bresp;
        bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        do @(posedge clk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        do @(posedge clk); while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : rd
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(n, e, d);
        chk(n, er, r);
    endtask : rchk
    task automatic wflow(input logic [31:0] d);
        logic [31:0] v;
        logic [1:0]  r;
        do rd(A_FLOW, v, r); while (v[0] !== 1'h0);
        wr(A_FLOW, d, 4'hF, r);
    endtask : wflow
    task automatic t_regs();
        logic [1:0] r;
        rchk("flow reset", A_FLOW, 32'h0, `PFC_RESP_OKAY);
        rchk("status reset", `PFC_ADDR_STAT, 32'h0, `PFC_RESP_OKAY);
        rchk("unmapped read", 8'h7C, 32'h0, `PFC_RESP_SLVERR);
        wr(8'h7C, 32'hFFFFFFFF, 4'hF, r);
        chk("unmapped write", `PFC_RESP_SLVERR, r);
        wflow(32'h00030007);
        rchk("flow readback", A_FLOW, 32'h00030006, `PFC_RESP_OKAY);
        wr(A_FLOW, 32'hFFFF0000, 4'h1, r);
        rchk("flow strobe", A_FLOW, 32'h00030000, `PFC_RESP_OKAY);
    endtask : t_regs
    task automatic t_tx();
        logic [1:0] r;
        i_peer.wait_cyc = 30;
        wr(A_CTRL, 32'h3, 4'h1, r);
        wr(A_AUTO, 32'h1, 4'h1, r);
        chk("pause request", 1, tx_req);
        chk("pause time sent", 16'h0003, tx_time);
        rchk("busy set", A_FLOW, 32'h00030001, `PFC_RESP_OKAY);
        repeat (60) if (tx_req === 1'h1) @(posedge clk);
        rchk("busy cleared", A_FLOW, 32'h00030000, `PFC_RESP_OKAY);
        i_peer.wait_cyc = 0;
        auto_req <= 1'h1;
        @(posedge clk);
        auto_req <= 1'h0;
        @(posedge clk);
        chk("pin request", 1, tx_req);
        repeat (20) if (tx_req === 1'h1) @(posedge clk);
        wr(A_CTRL, 32'h1, 4'h1, r);
        auto_req <= 1'h1;
        wr(A_AUTO, 32'h1, 4'h1, r);
        auto_req <= 1'h0;
        repeat (2) @(posedge clk);
        chk("request tx off", 0, tx_req);
    endtask : t_tx
    task automatic rx_case(input logic [3:0] ctl, input logic [2:0] fl, input logic bad, input logic ef, input int es);
        int         s0;
        int         b0;
        logic [1:0] r;
        wflow({16'h0003, 13'h0000, fl});
        wr(A_CTRL, {28'h0, ctl}, 4'h1, r);
        s0 = stall_n;
        b0 = byte_n;
        i_peer.send(16'h0003, bad);
        repeat (40) @(posedge clk);
        chk("filter", ef, got_f);
        chk("status err", bad, got_e);
        chk("stall cycles", es, stall_n - s0);
        chk("bytes and sof", 118, byte_n - b0);
    endtask : rx_case
    task automatic t_bp();
        logic [1:0] r;
        wflow(32'h00030002);
        wr(A_CTRL, 32'h2, 4'h1, r);
        cong <= 1'h1;
        repeat (3) @(posedge clk);
        chk("bp half duplex", 1, bp);
        wr(A_CTRL, 32'h0, 4'h1, r);
        repeat (3) @(posedge clk);
        chk("bp tx off", 0, bp);
        wr(A_CTRL, 32'h3, 4'h1, r);
        repeat (3) @(posedge clk);
        chk("bp full duplex", 0, bp);
        cong <= 1'h0;
    endtask : t_bp
    task automatic finish_test();
        if (bad_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        t_regs();
        t_tx();
        rx_case(4'h3, 3'h6, 1'h0, 1'h1, 3 * S100);
        rx_case(4'h3, 3'h2, 1'h0, 1'h0, 3 * S100);
        rx_case(4'h3, 3'h4, 1'h0, 1'h0, 0);
        rx_case(4'h7, 3'h0, 1'h0, 1'h1, 0);
        rx_case(4'hB, 3'h2, 1'h0, 1'h0, 3 * S10);
        rx_case(4'h2, 3'h2, 1'h0, 1'h0, 0);
        rx_case(4'h3, 3'h6, 1'h1, 1'h0, 0);
        t_bp();
        finish_test();
    end
    initial
    begin
        #100us;
        bad_count++;
        finish_test();
    end
endmodule : test_mac_pause_flow_control
